// File: verilog/perf_event_pkg.sv
// Event codes, unit masks, counter limits and prefetch queue sizing
// Shared by the event decoder and its bench; no clock or reset assumed
package perf_event_pkg;

    localparam logic [7:0] EVT_OFFCORE_OUTST   = 8'h60;
    localparam logic [7:0] EVT_CACHE_LOCK      = 8'h63;
    localparam logic [7:0] EVT_IO_TRANSACTIONS = 8'h6C;
    localparam logic [7:0] EVT_ICACHE          = 8'h80;
    localparam logic [7:0] EVT_NESTED_WALK     = 8'h4F;
    localparam logic [7:0] EVT_DCACHE_LINES    = 8'h51;
    localparam logic [7:0] EVT_LOAD_LOCK_FB    = 8'h52;

    localparam logic [7:0] UM_DEMAND_DATA_RD   = 8'h01;
    localparam logic [7:0] UM_DEMAND_CODE_RD   = 8'h02;
    localparam logic [7:0] UM_DEMAND_RFO       = 8'h04;
    localparam logic [7:0] UM_ANY_READ         = 8'h08;
    localparam logic [7:0] UM_BOTH_LOCK        = 8'h01;
    localparam logic [7:0] UM_DCACHE_LOCK      = 8'h02;
    localparam logic [7:0] UM_IO_DONE          = 8'h01;
    localparam logic [7:0] UM_FETCH_HITS       = 8'h01;
    localparam logic [7:0] UM_FETCH_MISSES     = 8'h02;
    localparam logic [7:0] UM_ALL_FETCHES      = 8'h03;
    localparam logic [7:0] UM_WALK_CYCLES      = 8'h10;
    localparam logic [7:0] UM_LINE_FILLS       = 8'h01;
    localparam logic [7:0] UM_SNOOP_EVICT      = 8'h08;
    localparam logic [7:0] UM_LOAD_LOCK        = 8'h01;

    // Bit n set: counter n may host the event
    localparam logic [3:0] CTR_MASK_C0         = 4'h1;
    localparam logic [3:0] CTR_MASK_C01        = 4'h3;
    localparam logic [3:0] CTR_MASK_ANY        = 4'hF;
    localparam logic [3:0] CTR_MASK_NONE       = 4'h0;

    localparam int         PF_QUEUE_DEPTH      = 4;

endpackage : perf_event_pkg

// File: verilog/perf_event_select_decode.sv
// Performance event decoder: turns event code, unit mask and counter
// index into a per-cycle increment, plus the data prefetch request queue.
// Assumes all event sources are on i_clk and single-cycle events are
// one-cycle pulses from the core; counter storage lives elsewhere.
// Function
// [RULE1] Demand data read occupancy, counter 0 only
// [RULE2] Demand code read occupancy, counter 0 only
// [RULE3] Demand ownership read occupancy, counter 0 only
// [RULE4] Any read occupancy incl. prefetch, counter 0
// [RULE5] Both caches locked cycles, counters 0,1
// [RULE6] Lock from uncacheable, split or walk
// [RULE7] Event observes locks, never causes them
// [RULE8] Data cache line locked cycles, counters 0,1
// [RULE9] One count per completed I/O transaction
// [RULE10] Count instruction fetches hitting the cache
// [RULE11] Count fetch misses including uncacheable fetches
// [RULE12] Each fetch miss counted exactly once
// [RULE13] Count all fetches including uncacheable bypasses
// [RULE14] Count nested page walk cycles
// [RULE15] Count data cache line fills, counters 0,1
// [RULE16] Count dirty evictions from snoop hit modified
// [RULE17] Count load-lock instructions accepted into fill buffer
// [RULE18] Four-entry prefetch queue, overwrites and competition
// [RULE19] Streamer stops on hit, pointer prefetcher continues
// [RULE20] Software avoids accesses locking both caches
// [RULE21] Occupancy adds outstanding request count per cycle
// [RULE22] Undefined selections produce no increments
`timescale 1ns/1ps
`default_nettype none

module perf_event_select_decode #(
    parameter int OCC_W   = 4,
    parameter int ADDR_W  = 32,
    parameter int PF_DEPTH = perf_event_pkg::PF_QUEUE_DEPTH,
    parameter int INC_W   = OCC_W + 2
) (
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire logic              i_count_en,
    input  wire logic [7:0]        i_event_code,
    input  wire logic [7:0]        i_unit_mask,
    input  wire logic [1:0]        i_counter_idx,
    input  wire logic [OCC_W-1:0]  i_occ_data_rd,
    input  wire logic [OCC_W-1:0]  i_occ_code_rd,
    input  wire logic [OCC_W-1:0]  i_occ_read_for_ownership,
    input  wire logic [OCC_W-1:0]  i_occ_l2_prefetch,
    input  wire logic              i_lock_uc_access,
    input  wire logic              i_lock_split_line,
    input  wire logic              i_lock_uc_walk,
    input  wire logic              i_dcache_line_locked,
    input  wire logic              i_io_done,
    input  wire logic              i_fetch_valid,
    input  wire logic              i_fetch_hit,
    input  wire logic              i_fetch_uncacheable,
    input  wire logic              i_nested_walk_active,
    input  wire logic              i_dcache_fill,
    input  wire logic              i_snoop_dirty_evict,
    input  wire logic              i_load_lock_fb_accept,
    input  wire logic              i_dcache_hit,
    input  wire logic              i_stream_req,
    input  wire logic [ADDR_W-1:0] i_stream_addr,
    input  wire logic              i_ip_req,
    input  wire logic [ADDR_W-1:0] i_ip_addr,
    input  wire logic              i_pf_ready,
    output logic      [INC_W-1:0]  o_inc,
    output logic                   o_event_legal,
    output logic                   o_both_locked,
    output logic                   o_pf_valid,
    output logic      [ADDR_W-1:0] o_pf_addr,
    output logic                   o_pf_overwrite,
    output logic                   o_pf_compete_drop
);
    import perf_event_pkg::*;

    localparam int PTR_W = (PF_DEPTH > 1) ? $clog2(PF_DEPTH) : 1;
    localparam int CNT_W = $clog2(PF_DEPTH + 1);
    localparam logic [CNT_W-1:0] PF_FULL = CNT_W'(PF_DEPTH);

    function automatic logic [INC_W-1:0] widen_bit(input logic b);
        widen_bit = {{(INC_W-1){1'b0}}, b};
    endfunction : widen_bit

    function automatic logic [INC_W-1:0] widen_occ(input logic [OCC_W-1:0] v);
        widen_occ = {{(INC_W-OCC_W){1'b0}}, v};
    endfunction : widen_occ

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_W'(PF_DEPTH - 1)) ? '0 : p + PTR_W'(1);
    endfunction : ptr_inc

    // Lock level is only read here; nothing drives back into the caches
    logic lock_both; // [RULE7]
    assign lock_both = i_lock_uc_access | i_lock_split_line | i_lock_uc_walk; // [RULE6]

    // Fetch events rely on i_fetch_valid being one pulse per fetch,
    // so a miss that stays outstanding still adds only one
    logic fetch_hit_evt;
    logic fetch_miss_evt;
    assign fetch_hit_evt  = i_fetch_valid & i_fetch_hit & ~i_fetch_uncacheable;
    assign fetch_miss_evt = i_fetch_valid & ~(i_fetch_hit & ~i_fetch_uncacheable); // [RULE12]

    logic [INC_W-1:0] inc_raw;
    logic [3:0]       ctr_allowed;

    always_comb begin
        inc_raw     = '0;
        ctr_allowed = CTR_MASK_NONE; // [RULE22]
        unique case (i_event_code)
            EVT_OFFCORE_OUTST: begin
                ctr_allowed = CTR_MASK_C0;
                unique case (i_unit_mask)
                    UM_DEMAND_DATA_RD: inc_raw = widen_occ(i_occ_data_rd); // [RULE1] [RULE21]
                    UM_DEMAND_CODE_RD: inc_raw = widen_occ(i_occ_code_rd); // [RULE2] [RULE21]
                    UM_DEMAND_RFO: inc_raw = widen_occ(i_occ_read_for_ownership); // [RULE3]
                    UM_ANY_READ: begin
                        inc_raw = widen_occ(i_occ_data_rd) + widen_occ(i_occ_code_rd)
                                + widen_occ(i_occ_read_for_ownership)
                                + widen_occ(i_occ_l2_prefetch); // [RULE4] [RULE21]
                    end
                    default: ctr_allowed = CTR_MASK_NONE; // [RULE22]
                endcase
            end
            EVT_CACHE_LOCK: begin
                ctr_allowed = CTR_MASK_C01;
                unique case (i_unit_mask)
                    UM_BOTH_LOCK: inc_raw = widen_bit(lock_both); // [RULE5]
                    UM_DCACHE_LOCK: inc_raw = widen_bit(i_dcache_line_locked); // [RULE8]
                    default: ctr_allowed = CTR_MASK_NONE;
                endcase
            end
            EVT_IO_TRANSACTIONS: begin
                if (i_unit_mask == UM_IO_DONE) begin
                    ctr_allowed = CTR_MASK_ANY;
                    inc_raw     = widen_bit(i_io_done); // [RULE9]
                end
            end
            EVT_ICACHE: begin
                ctr_allowed = CTR_MASK_ANY;
                unique case (i_unit_mask)
                    UM_FETCH_HITS: inc_raw = widen_bit(fetch_hit_evt); // [RULE10]
                    UM_FETCH_MISSES: inc_raw = widen_bit(fetch_miss_evt); // [RULE11]
                    UM_ALL_FETCHES: inc_raw = widen_bit(i_fetch_valid); // [RULE13]
                    default: ctr_allowed = CTR_MASK_NONE;
                endcase
            end
            EVT_NESTED_WALK: begin
                if (i_unit_mask == UM_WALK_CYCLES) begin
                    ctr_allowed = CTR_MASK_ANY;
                    inc_raw     = widen_bit(i_nested_walk_active); // [RULE14]
                end
            end
            EVT_DCACHE_LINES: begin
                unique case (i_unit_mask)
                    UM_LINE_FILLS: begin
                        ctr_allowed = CTR_MASK_C01;
                        inc_raw     = widen_bit(i_dcache_fill); // [RULE15]
                    end
                    UM_SNOOP_EVICT: begin
                        ctr_allowed = CTR_MASK_C01;
                        inc_raw     = widen_bit(i_snoop_dirty_evict); // [RULE16]
                    end
                    default: ctr_allowed = CTR_MASK_NONE;
                endcase
            end
            EVT_LOAD_LOCK_FB: begin
                if (i_unit_mask == UM_LOAD_LOCK) begin
                    ctr_allowed = CTR_MASK_ANY;
                    inc_raw     = widen_bit(i_load_lock_fb_accept); // [RULE17]
                end
            end
            default: ctr_allowed = CTR_MASK_NONE; // [RULE22]
        endcase
    end

    logic legal;
    assign legal = ctr_allowed[i_counter_idx];

    // Registered so the counter sees one stable increment per cycle
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_inc         <= '0;
            o_event_legal <= 1'b0;
        end else begin
            o_event_legal <= legal;
            o_inc         <= (legal && i_count_en) ? inc_raw : '0; // [RULE22]
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_both_locked <= 1'b0;
        end else begin
            o_both_locked <= lock_both; // [RULE6]
        end
    end

    // Prefetch request queue
    logic [ADDR_W-1:0] pf_mem_reg [PF_DEPTH];
    logic [ADDR_W-1:0] pf_mem_next [PF_DEPTH];
    logic [PTR_W-1:0]  wr_ptr_reg;
    logic [PTR_W-1:0]  wr_ptr_next;
    logic [PTR_W-1:0]  rd_ptr_reg;
    logic [PTR_W-1:0]  rd_ptr_next;
    logic [CNT_W-1:0]  cnt_reg;
    logic [CNT_W-1:0]  cnt_next;
    logic              stream_live;
    logic              push;
    logic              pop;
    logic              overwrite;
    logic [ADDR_W-1:0] push_addr;

    assign stream_live = i_stream_req & ~i_dcache_hit; // [RULE19]
    // Streamer wins a same-cycle collision; the pointer request is lost
    assign push      = stream_live | i_ip_req; // [RULE18]
    assign push_addr = stream_live ? i_stream_addr : i_ip_addr;
    assign pop       = o_pf_valid & i_pf_ready;
    // Full queue with no drain: newest overwrites the oldest entry
    assign overwrite = push & ~pop & (cnt_reg == PF_FULL); // [RULE18]

    always_comb begin
        pf_mem_next = pf_mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        cnt_next    = cnt_reg;
        if (pop) begin
            rd_ptr_next = ptr_inc(rd_ptr_reg);
            cnt_next    = cnt_next - CNT_W'(1);
        end
        if (push) begin
            pf_mem_next[wr_ptr_reg] = push_addr;
            wr_ptr_next             = ptr_inc(wr_ptr_reg);
            if (overwrite) begin
                rd_ptr_next = ptr_inc(rd_ptr_reg);
            end else begin
                cnt_next = cnt_next + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            for (int i = 0; i < PF_DEPTH; i++) begin
                pf_mem_reg[i] <= '0;
            end
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            pf_mem_reg <= pf_mem_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg    <= cnt_next;
        end
    end

    // Head is registered from next state so the outputs stay flop-driven
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_pf_valid <= 1'b0;
            o_pf_addr  <= '0;
        end else begin
            o_pf_valid <= (cnt_next != '0);
            o_pf_addr  <= pf_mem_next[rd_ptr_next];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_pf_overwrite    <= 1'b0;
            o_pf_compete_drop <= 1'b0;
        end else begin
            o_pf_overwrite    <= overwrite; // [RULE18]
            o_pf_compete_drop <= stream_live & i_ip_req; // [RULE18]
        end
    end

endmodule : perf_event_select_decode

`default_nettype wire

// File: tb/perf_event_select_decode_monitor.sv
// Assertions on the event decoder and prefetch queue outputs
// Bound to the decoder top; sees only its ports, one clock domain
`timescale 1ns/1ps
`default_nettype none
module perf_event_select_decode_monitor #(
    parameter int INC_W = 6
) (
    input wire logic             i_clk,
    input wire logic             i_rstn,
    input wire logic [7:0]       i_event_code,
    input wire logic [7:0]       i_unit_mask,
    input wire logic [1:0]       i_counter_idx,
    input wire logic             i_lock_uc_access,
    input wire logic             i_lock_split_line,
    input wire logic             i_lock_uc_walk,
    input wire logic             i_fetch_valid,
    input wire logic             i_dcache_hit,
    input wire logic             i_stream_req,
    input wire logic             i_ip_req,
    input wire logic [INC_W-1:0] o_inc,
    input wire logic             o_event_legal,
    input wire logic             o_both_locked,
    input wire logic             o_pf_compete_drop
);
    default clocking mon_cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    logic lock_any;
    assign lock_any = i_lock_uc_access | i_lock_split_line | i_lock_uc_walk;

    lock_follow_a: assert property (lock_any |=> o_both_locked)
        else $error("lock cause not reflected");
    lock_passive_a: assert property (
        i_event_code == 8'h63 && i_unit_mask == 8'h01 && !lock_any |=> o_inc == '0)
        else $error("lock count without a lock cause");
    offcore_c0_a: assert property (
        i_event_code == 8'h60 && i_counter_idx != 2'd0 |=> !o_event_legal && o_inc == '0)
        else $error("offcore event allowed off counter 0");
    lock_c01_a: assert property (
        i_event_code == 8'h63 && i_counter_idx[1] |-> ##1 !o_event_legal)
        else $error("lock event allowed above counter 1");
    fill_c01_a: assert property (
        i_event_code == 8'h51 && i_unit_mask == 8'h01 && i_counter_idx[1] |=> o_inc == '0)
        else $error("line fill counted above counter 1");
    miss_once_a: assert property (
        i_event_code == 8'h80 && i_unit_mask == 8'h02 && !i_fetch_valid |=> o_inc == '0)
        else $error("fetch miss counted without a fetch");
    undefined_mask_a: assert property (
        i_event_code == 8'h51 && i_unit_mask != 8'h01 && i_unit_mask != 8'h08
        |=> !o_event_legal && o_inc == '0)
        else $error("undefined selection counted");
    compete_drop_a: assert property (
        i_stream_req && !i_dcache_hit && i_ip_req |=> o_pf_compete_drop)
        else $error("competing requests without drop pulse");
endmodule : perf_event_select_decode_monitor

bind perf_event_select_decode perf_event_select_decode_monitor #(.INC_W(INC_W)) u_monitor (.*);
`default_nettype wire

// File: tb/perf_event_sources.sv
// Core pipeline and cache event sources with random activity
// Assumes one clock; every change lands on the falling edge
`timescale 1ns/1ps
`default_nettype none
module perf_event_sources #(
    parameter int OCC_W = 4
) (
    input  wire logic             i_clk,
    output logic      [OCC_W-1:0] o_occ_data_rd,
    output logic      [OCC_W-1:0] o_occ_code_rd,
    output logic      [OCC_W-1:0] o_occ_rfo,
    output logic      [OCC_W-1:0] o_occ_l2_prefetch,
    output logic      [11:0]      o_flags
);
    logic [31:0] seed = 32'h924A1E11;
    logic [31:0] r;
    logic [31:0] q;
    initial begin
        {o_occ_data_rd, o_occ_code_rd, o_occ_rfo, o_occ_l2_prefetch} = '0;
        o_flags = '0;
    end
    // Flags: lock causes, line lock, io done, fetch valid/hit/uncached,
    // nested walk, fill, snoop evict, load-lock accept
    always @(negedge i_clk) begin
        r = $random(seed);
        q = $random(seed);
        {o_occ_data_rd, o_occ_code_rd, o_occ_rfo, o_occ_l2_prefetch} <= (4*OCC_W)'(r);
        // Locks kept rare, as software shuns them
        o_flags[2:0] <= q[18:16] & q[21:19] & q[24:22];
        o_flags[11:3] <= q[8:0];
    end
endmodule : perf_event_sources
`default_nettype wire

// File: tb/perf_event_select_decode_bench.sv
// Bench: random traffic under every selection, then prefetch queue corners
// Assumes decoder answers one cycle after the sampling edge
`timescale 1ns/1ps
`default_nettype none
module perf_event_select_decode_bench;
    import perf_event_pkg::*;
    localparam int INC_W = 6;
    localparam int LIMIT = 2000;
    logic             i_clk = 1'b0;
    logic             i_rstn = 1'b0;
    logic             i_count_en, i_dcache_hit, i_stream_req, i_ip_req, i_pf_ready;
    logic [7:0]       i_event_code, i_unit_mask;
    logic [1:0]       i_counter_idx;
    logic [31:0]      i_stream_addr, i_ip_addr, o_pf_addr, base;
    logic [31:0]      seed = 32'h924A1E11;
    wire  [3:0]       i_occ_data_rd, i_occ_code_rd, i_occ_read_for_ownership, i_occ_l2_prefetch;
    wire  [11:0]      flags;
    logic [INC_W-1:0] o_inc, exp_inc;
    logic             o_event_legal, o_both_locked, o_pf_valid, o_pf_overwrite, o_pf_compete_drop;
    logic             exp_legal, exp_lock;
    logic [15:0]      sel [17] = '{16'h6001, 16'h6002, 16'h6004, 16'h6008, 16'h6301, 16'h6302,
        16'h6C01, 16'h8001, 16'h8002, 16'h8003, 16'h4F10, 16'h5101, 16'h5108, 16'h5201,
        16'h6010, 16'h8004, 16'h5102};
    int               checks = 0, err_total = 0, cycles = 0;

    perf_event_sources u_src (.i_clk(i_clk), .o_occ_data_rd(i_occ_data_rd),
        .o_occ_code_rd(i_occ_code_rd), .o_occ_rfo(i_occ_read_for_ownership),
        .o_occ_l2_prefetch(i_occ_l2_prefetch), .o_flags(flags));
    perf_event_select_decode u_dut (.*,
        .i_lock_uc_access(flags[0]), .i_lock_split_line(flags[1]), .i_lock_uc_walk(flags[2]),
        .i_dcache_line_locked(flags[3]), .i_io_done(flags[4]), .i_fetch_valid(flags[5]),
        .i_fetch_hit(flags[6]), .i_fetch_uncacheable(flags[7]), .i_nested_walk_active(flags[8]),
        .i_dcache_fill(flags[9]), .i_snoop_dirty_evict(flags[10]),
        .i_load_lock_fb_accept(flags[11]));

    initial forever #20 i_clk = ~i_clk;

    function automatic logic [INC_W:0] expect_of();
        logic [INC_W-1:0] v;
        logic             ok;
        ok = 1'b1;
        v = '0;
        case ({i_event_code, i_unit_mask})
            {EVT_OFFCORE_OUTST, UM_DEMAND_DATA_RD}: v = INC_W'(i_occ_data_rd);
            {EVT_OFFCORE_OUTST, UM_DEMAND_CODE_RD}: v = INC_W'(i_occ_code_rd);
            {EVT_OFFCORE_OUTST, UM_DEMAND_RFO}:     v = INC_W'(i_occ_read_for_ownership);
            {EVT_OFFCORE_OUTST, UM_ANY_READ}:       v = INC_W'(i_occ_data_rd)
                + INC_W'(i_occ_code_rd) + INC_W'(i_occ_read_for_ownership)
                + INC_W'(i_occ_l2_prefetch);
            {EVT_CACHE_LOCK, UM_BOTH_LOCK}:         v = INC_W'(|flags[2:0]);
            {EVT_CACHE_LOCK, UM_DCACHE_LOCK}:       v = INC_W'(flags[3]);
            {EVT_IO_TRANSACTIONS, UM_IO_DONE}:      v = INC_W'(flags[4]);
            {EVT_ICACHE, UM_FETCH_HITS}:            v = INC_W'(flags[5] & flags[6] & !flags[7]);
            {EVT_ICACHE, UM_FETCH_MISSES}:          v = INC_W'(flags[5] & !(flags[6] & !flags[7]));
            {EVT_ICACHE, UM_ALL_FETCHES}:           v = INC_W'(flags[5]);
            {EVT_NESTED_WALK, UM_WALK_CYCLES}:      v = INC_W'(flags[8]);
            {EVT_DCACHE_LINES, UM_LINE_FILLS}:      v = INC_W'(flags[9]);
            {EVT_DCACHE_LINES, UM_SNOOP_EVICT}:     v = INC_W'(flags[10]);
            {EVT_LOAD_LOCK_FB, UM_LOAD_LOCK}:       v = INC_W'(flags[11]);
            default:                                ok = 1'b0;
        endcase
        if (i_event_code == EVT_OFFCORE_OUTST && i_counter_idx != 2'd0) ok = 1'b0;
        if ((i_event_code == EVT_CACHE_LOCK || i_event_code == EVT_DCACHE_LINES)
            && i_counter_idx[1]) ok = 1'b0;
        if (!ok || !i_count_en) v = '0;
        return {ok, v};
    endfunction : expect_of

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", name, want, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Expectation taken from the values the decoder samples at this edge
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        {exp_legal, exp_inc} <= i_rstn ? expect_of() : '0;
        exp_lock <= i_rstn && (|flags[2:0]);
        if (cycles == LIMIT) begin
            err_total++;
            end_of_test();
        end
    end

    always @(negedge i_clk) begin
        check("o_inc", o_inc, exp_inc);
        check("o_event_legal", o_event_legal, exp_legal);
        check("o_both_locked", o_both_locked, exp_lock);
    end

    initial begin
        {i_count_en, i_dcache_hit, i_stream_req, i_ip_req, i_pf_ready} = '0;
        {i_event_code, i_unit_mask, i_counter_idx, i_stream_addr, i_ip_addr} = '0;
        repeat (4) @(negedge i_clk);
        i_rstn = 1'b1;
        for (int t = 0; t < 17; t++) begin
            for (int n = 0; n < 40; n++) begin
                @(negedge i_clk);
                {i_event_code, i_unit_mask} = sel[t];
                i_counter_idx = 2'($random(seed));
                i_count_en = ($random(seed) & 3) != 0;
                {i_stream_req, i_ip_req, i_dcache_hit, i_pf_ready} = 4'($random(seed));
                i_stream_addr = $random(seed);
                i_ip_addr = $random(seed);
            end
            $display("selection %0d done", t);
        end
        // Mid-run reset empties the queue before the corner cases
        i_rstn = 1'b0;
        @(negedge i_clk);
        {i_stream_req, i_ip_req, i_dcache_hit, i_pf_ready} = '0;
        i_rstn = 1'b1;
        base = $random(seed);
        for (int k = 0; k < 5; k++) begin
            @(negedge i_clk);
            i_ip_req = 1'b1;
            i_ip_addr = base + k;
        end
        @(negedge i_clk);
        i_ip_req = 1'b0;
        check("o_pf_overwrite", o_pf_overwrite, 1);
        for (int k = 1; k < 5; k++) begin
            check("o_pf_addr", o_pf_addr, base + k);
            i_pf_ready = 1'b1;
            @(negedge i_clk);
        end
        check("o_pf_valid", o_pf_valid, 0);
        {i_stream_req, i_ip_req, i_dcache_hit, i_pf_ready} = 4'b1100;
        i_stream_addr = ~base;
        i_ip_addr = base;
        @(negedge i_clk);
        {i_stream_req, i_ip_req, i_dcache_hit, i_pf_ready} = 4'b1011;
        check("o_pf_compete_drop", o_pf_compete_drop, 1);
        check("o_pf_addr", o_pf_addr, ~base);
        @(negedge i_clk);
        {i_stream_req, i_ip_req, i_dcache_hit, i_pf_ready} = 4'b0111;
        check("o_pf_valid", o_pf_valid, 0);
        @(negedge i_clk);
        {i_stream_req, i_ip_req, i_dcache_hit, i_pf_ready} = '0;
        check("o_pf_addr", o_pf_addr, base);
        $display("prefetch queue test done");
        end_of_test();
    end
endmodule : perf_event_select_decode_bench
`default_nettype wire
